// >>> ftps_defines.svh
// Constants for the FSK tone parameter selection block.
// Assumes a 20 MHz master clock on ref_clk_i and 32-bit AXI4-Lite data.
`ifndef FTPS_DEFINES_SVH
`define FTPS_DEFINES_SVH

`define FTPS_CLK_HZ        20000000
`define FTPS_ADDR_W        4
`define FTPS_OFF_CTRL      4'h0
`define FTPS_OFF_STATUS    4'h4

`define FTPS_CH_LSB        0
`define FTPS_CH_MSB        2
`define FTPS_BAUD_LSB      3
`define FTPS_BAUD_MSB      4
`define FTPS_DEV_BIT       5

`define FTPS_ST_TXF_LSB    0
`define FTPS_ST_TXF_MSB    2
`define FTPS_ST_RXF_LSB    3
`define FTPS_ST_RXF_MSB    5
`define FTPS_ST_TONE_BIT   6
`define FTPS_ST_TXB_BIT    7
`define FTPS_ST_RT_LSB     8
`define FTPS_ST_RT_MSB     15

`define FTPS_RST_CH        3'h0
`define FTPS_RST_BAUD      2'h2
`define FTPS_RST_DEV       1'h0

`define FTPS_CH0_HZ        18'd60000
`define FTPS_CH1_HZ        18'd66000
`define FTPS_CH2_HZ        18'd72000
`define FTPS_CH3_HZ        18'd76000
`define FTPS_CH4_HZ        18'd82050
`define FTPS_CH5_HZ        18'd86000
`define FTPS_CH6_HZ        18'd110000
`define FTPS_CH7_HZ        18'd132500

`define FTPS_BAUD600_HZ    13'd600
`define FTPS_BAUD1200_HZ   13'd1200
`define FTPS_BAUD2400_HZ   13'd2400
`define FTPS_BAUD4800_HZ   13'd4800

// Bit period in microseconds as printed, and in master clock cycles less one.
`define FTPS_BP600_US      1667
`define FTPS_BP1200_US     833
`define FTPS_BP2400_US     417
`define FTPS_BP4800_US     208
`define FTPS_BP600_CYC     16'((`FTPS_CLK_HZ / 600) - 1)
`define FTPS_BP1200_CYC    16'((`FTPS_CLK_HZ / 1200) - 1)
`define FTPS_BP2400_CYC    16'((`FTPS_CLK_HZ / 2400) - 1)
`define FTPS_BP4800_CYC    16'((`FTPS_CLK_HZ / 4800) - 1)

// Phase step per hertz: 2^48 / 20 MHz, used with a 42-bit product shifted by 16.
`define FTPS_INC_MUL       24'd14073749
`define FTPS_INC_SHIFT     16

`define FTPS_RESP_OKAY     2'h0
`define FTPS_RESP_SLVERR   2'h2

`endif

// >>> ftps_pkg.sv
// Types for the FSK tone parameter selection block.
// Assumes nothing beyond the constants header.
`default_nettype none
package ftps_pkg;
    typedef enum logic [1:0] {
        FTPS_BAUD_600  = 2'h0,
        FTPS_BAUD_1200 = 2'h1,
        FTPS_BAUD_2400 = 2'h2,
        FTPS_BAUD_4800 = 2'h3
    } ftps_baud_e;
    typedef logic [2:0] ftps_chan_t;
endpackage : ftps_pkg
`default_nettype wire

// >>> ftps_tone_select.sv
// FSK tone parameter selection: control register, bit period timer and tone generator.
// Assumes an AXI4-Lite master on ref_clk_i and an asynchronous transmit data pin.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`include "ftps_defines.svh"
`default_nettype none

module ftps_tone_select (
    input  wire logic                     ref_clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic [`FTPS_ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    input  wire logic [`FTPS_ADDR_W-1:0]  s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    input  wire logic                     tx_data_i,
    output logic                          tone_o,
    output logic                          bit_tick_o,
    output logic [2:0]                    tx_filter_sel_o,
    output logic [2:0]                    rx_filter_sel_o,
    output logic                          filter_retune_o
);

    function automatic logic [17:0] chan_hz(input ftps_pkg::ftps_chan_t ch);
        unique case (ch)
            3'h0: chan_hz = `FTPS_CH0_HZ;
            3'h1: chan_hz = `FTPS_CH1_HZ;
            3'h2: chan_hz = `FTPS_CH2_HZ;
            3'h3: chan_hz = `FTPS_CH3_HZ;
            3'h4: chan_hz = `FTPS_CH4_HZ;
            3'h5: chan_hz = `FTPS_CH5_HZ;
            3'h6: chan_hz = `FTPS_CH6_HZ;
            3'h7: chan_hz = `FTPS_CH7_HZ;
        endcase
    endfunction : chan_hz

    function automatic logic [12:0] baud_hz(input ftps_pkg::ftps_baud_e b);
        unique case (b)
            ftps_pkg::FTPS_BAUD_600:  baud_hz = `FTPS_BAUD600_HZ;
            ftps_pkg::FTPS_BAUD_1200: baud_hz = `FTPS_BAUD1200_HZ;
            ftps_pkg::FTPS_BAUD_2400: baud_hz = `FTPS_BAUD2400_HZ;
            ftps_pkg::FTPS_BAUD_4800: baud_hz = `FTPS_BAUD4800_HZ;
        endcase
    endfunction : baud_hz

    function automatic logic [15:0] bit_period_cyc(input ftps_pkg::ftps_baud_e b);
        unique case (b)
            ftps_pkg::FTPS_BAUD_600:  bit_period_cyc = `FTPS_BP600_CYC;
            ftps_pkg::FTPS_BAUD_1200: bit_period_cyc = `FTPS_BP1200_CYC;
            ftps_pkg::FTPS_BAUD_2400: bit_period_cyc = `FTPS_BP2400_CYC;
            ftps_pkg::FTPS_BAUD_4800: bit_period_cyc = `FTPS_BP4800_CYC;
        endcase
    endfunction : bit_period_cyc

    // Control state.
    ftps_pkg::ftps_chan_t  chan_q;
    ftps_pkg::ftps_baud_e  baud_q;
    logic                  dev_full_q;
    logic [7:0]            retune_cnt_q;
    logic                  tx_bit_q;

    // Write channel state.
    logic                     awready_q;
    logic                     wready_q;
    logic                     aw_got_q;
    logic                     w_got_q;
    logic [`FTPS_ADDR_W-1:0]  waddr_q;
    logic [31:0]              wdata_q;
    logic [3:0]               wstrb_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;

    // Read channel state.
    logic         arready_q;
    logic         rvalid_q;
    logic [1:0]   rresp_q;
    logic [31:0]  rdata_q;

    logic         aw_fire;
    logic         w_fire;
    logic         wr_go;
    logic         ar_fire;

    assign aw_fire = s_axi_awvalid_i & awready_q;
    assign w_fire  = s_axi_wvalid_i & wready_q;
    assign wr_go   = aw_got_q & w_got_q & ~bvalid_q;
    assign ar_fire = s_axi_arvalid_i & arready_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            awready_q <= 1'b1;
            aw_got_q  <= 1'b0;
            waddr_q   <= '0;
        end else begin
            if (aw_fire) begin
                awready_q <= 1'b0;
                aw_got_q  <= 1'b1;
                waddr_q   <= s_axi_awaddr_i;
            end else if (bvalid_q && s_axi_bready_i) begin
                awready_q <= 1'b1;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wready_q <= 1'b1;
            w_got_q  <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else begin
            if (w_fire) begin
                wready_q <= 1'b0;
                w_got_q  <= 1'b1;
                wdata_q  <= s_axi_wdata_i;
                wstrb_q  <= s_axi_wstrb_i;
            end else if (bvalid_q && s_axi_bready_i) begin
                wready_q <= 1'b1;
            end
            if (wr_go) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `FTPS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (waddr_q == `FTPS_OFF_CTRL || waddr_q == `FTPS_OFF_STATUS) ?
                        `FTPS_RESP_OKAY : `FTPS_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // The control register is live at all times; no reset or configuration mode is needed to change channel.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chan_q     <= `FTPS_RST_CH;
            baud_q     <= ftps_pkg::ftps_baud_e'(`FTPS_RST_BAUD);
            dev_full_q <= `FTPS_RST_DEV;
        end else if (wr_go && waddr_q == `FTPS_OFF_CTRL && wstrb_q[0]) begin
            chan_q     <= wdata_q[`FTPS_CH_MSB:`FTPS_CH_LSB];
            baud_q     <= ftps_pkg::ftps_baud_e'(wdata_q[`FTPS_BAUD_MSB:`FTPS_BAUD_LSB]);
            // Half deviation has no meaning at 600 baud, so it is stored as full deviation.
            dev_full_q <= wdata_q[`FTPS_DEV_BIT] |
                          (wdata_q[`FTPS_BAUD_MSB:`FTPS_BAUD_LSB] == 2'(ftps_pkg::FTPS_BAUD_600));
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `FTPS_RESP_OKAY;
            rdata_q   <= '0;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= `FTPS_RESP_OKAY;
            rdata_q   <= '0;
            if (s_axi_araddr_i == `FTPS_OFF_CTRL) begin
                rdata_q[`FTPS_CH_MSB:`FTPS_CH_LSB]     <= chan_q;
                rdata_q[`FTPS_BAUD_MSB:`FTPS_BAUD_LSB] <= baud_q;
                rdata_q[`FTPS_DEV_BIT]                 <= dev_full_q;
            end else if (s_axi_araddr_i == `FTPS_OFF_STATUS) begin
                rdata_q[`FTPS_ST_TXF_MSB:`FTPS_ST_TXF_LSB] <= tx_filter_sel_o;
                rdata_q[`FTPS_ST_RXF_MSB:`FTPS_ST_RXF_LSB] <= rx_filter_sel_o;
                rdata_q[`FTPS_ST_TONE_BIT]                 <= tone_o;
                rdata_q[`FTPS_ST_TXB_BIT]                  <= tx_bit_q;
                rdata_q[`FTPS_ST_RT_MSB:`FTPS_ST_RT_LSB]   <= retune_cnt_q;
            end else begin
                rresp_q <= `FTPS_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Both filters follow the one selected channel together, so the device never spans two channels.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_filter_sel_o <= `FTPS_RST_CH;
            rx_filter_sel_o <= `FTPS_RST_CH;
            filter_retune_o <= 1'b0;
            retune_cnt_q    <= '0;
        end else begin
            tx_filter_sel_o <= chan_q;
            rx_filter_sel_o <= chan_q;
            filter_retune_o <= (chan_q != tx_filter_sel_o);
            if (chan_q != tx_filter_sel_o) begin
                retune_cnt_q <= retune_cnt_q + 8'h01;
            end
        end
    end

    // Transmit data pin passes two flip-flops before use.
    logic        tx_sync1_q;
    logic        tx_sync2_q;
    logic [15:0] bit_cnt_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_sync1_q <= 1'b1;
            tx_sync2_q <= 1'b1;
        end else begin
            tx_sync1_q <= tx_data_i;
            tx_sync2_q <= tx_sync1_q;
        end
    end

    // A bit period change restarts the count, so the first tick after a baud change is a full period.
    ftps_pkg::ftps_baud_e baud_seen_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt_q   <= '0;
            baud_seen_q <= ftps_pkg::ftps_baud_e'(`FTPS_RST_BAUD);
            bit_tick_o  <= 1'b0;
            tx_bit_q    <= 1'b1;
        end else begin
            baud_seen_q <= baud_q;
            bit_tick_o  <= 1'b0;
            if (baud_seen_q != baud_q) begin
                bit_cnt_q <= '0;
            end else if (bit_cnt_q >= bit_period_cyc(baud_q)) begin
                bit_cnt_q  <= '0;
                bit_tick_o <= 1'b1;
                tx_bit_q   <= tx_sync2_q;
            end else begin
                bit_cnt_q <= bit_cnt_q + 16'h0001;
            end
        end
    end

    // Tone frequency and its phase step.
    logic [17:0] half_space_hz;
    logic [17:0] tone_hz;
    logic [41:0] inc_prod;
    logic [31:0] inc_q;
    logic [31:0] phase_q;

    always_comb begin
        logic [12:0] b;
        b = baud_hz(baud_q);
        half_space_hz = dev_full_q ? 18'(b >> 1) : 18'(b >> 2);
        tone_hz = tx_bit_q ? chan_hz(tx_filter_sel_o) - half_space_hz
                           : chan_hz(tx_filter_sel_o) + half_space_hz;
        inc_prod = 42'(tone_hz) * 42'(`FTPS_INC_MUL);
    end

    // A phase accumulator divides the master clock; the average tone is exact to a fraction of a hertz
    // while each cycle is a whole number of master clocks, which is the rounding that a divider brings.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            inc_q   <= '0;
            phase_q <= '0;
            tone_o  <= 1'b0;
        end else begin
            inc_q   <= inc_prod[`FTPS_INC_SHIFT +: 32];
            phase_q <= phase_q + inc_q;
            tone_o  <= phase_q[31];
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rresp_o   = rresp_q;
    assign s_axi_rdata_o   = rdata_q;

endmodule : ftps_tone_select
`default_nettype wire

// >>> ftps_tone_select_chk.sv
// Port assertions for the tone selection block.
// Assumes it is bound into ftps_tone_select and sees only its ports.
`default_nettype none
module ftps_tone_select_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        bit_tick_o,
    input wire logic [2:0]  tx_filter_sel_o,
    input wire logic [2:0]  rx_filter_sel_o,
    input wire logic        filter_retune_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    sequence sel_moved;
        tx_filter_sel_o != $past(tx_filter_sel_o);
    endsequence
    AST_SEL_SAME: assert property (tx_filter_sel_o == rx_filter_sel_o)
        else $error("Filter selections differ.");
    AST_RETUNE_ON_CHANGE: assert property (sel_moved |-> filter_retune_o)
        else $error("Channel moved without a retune pulse.");
    AST_RETUNE_CAUSE: assert property (filter_retune_o |-> sel_moved)
        else $error("Retune pulse without a channel change.");
    AST_RETUNE_PULSE: assert property (filter_retune_o |=> !filter_retune_o)
        else $error("Retune pulse longer than one cycle.");
    AST_SEL_WHEN: assert property (sel_moved |-> $past(s_axi_bvalid_o))
        else $error("Channel moved outside a register write.");
    AST_TICK_GAP: assert property (bit_tick_o |=> !bit_tick_o [*8])
        else $error("Bit ticks too close together.");
    AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response dropped early.");
    AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("Read data dropped early.");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid_o)
        else $error("Read not answered in one cycle.");
endmodule : ftps_tone_select_chk
bind ftps_tone_select ftps_tone_select_chk u_chk (.ref_clk_i, .reset_n_i, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .bit_tick_o, .tx_filter_sel_o, .rx_filter_sel_o, .filter_retune_o);
`default_nettype wire

// >>> ftps_line_peer.sv
// Receiving modem on the line: times sixteen tone periods in master clock cycles.
// Assumes the tone is a square wave in the clk_i domain and start_i is a one-cycle request.
`default_nettype none
module ftps_line_peer (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   tone_i,
    input  wire logic   start_i,
    output logic        done_o,
    output logic [19:0] cycles_o
);
    logic       tone_q;
    logic [1:0] state_q;
    logic [4:0] rises_q;
    wire        rise = tone_i && !tone_q;
    // Sixteen periods average out the one-clock jitter of a divided tone.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_q   <= 1'b0;
            state_q  <= 2'h0;
            rises_q  <= 5'h0;
            done_o   <= 1'b0;
            cycles_o <= 20'h0;
        end else begin
            tone_q <= tone_i;
            if (start_i) begin
                state_q <= 2'h1;
                done_o  <= 1'b0;
            end else if (state_q == 2'h1 && rise) begin
                state_q  <= 2'h2;
                rises_q  <= 5'h0;
                cycles_o <= 20'h0;
            end else if (state_q == 2'h2) begin
                cycles_o <= cycles_o + 20'h1;
                rises_q  <= rises_q + 5'(rise);
                if (rise && rises_q == 5'hf) begin
                    state_q <= 2'h0;
                    done_o  <= 1'b1;
                end
            end
        end
    end
endmodule : ftps_line_peer
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the tone selection block with a line receiver model.
// Assumes the design, the checker and ftps_line_peer are compiled before it.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rb;
        int          hz;
    } ftps_row_s;
    logic ref_clk_i, reset_n_i, tx_data_i, start, done, tone_o, bit_tick_o, filter_retune_o;
    logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [3:0]  s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [2:0]  tx_filter_sel_o, rx_filter_sel_o, prev;
    logic [19:0] cyc;
    int          err_total = 0, checks = 0, rt_n = 0, n, k;
    // A 600 baud row written with deviation 0.5 reads back with deviation 1.
    ftps_row_s   rows [8] = '{'{32'h00, 32'h20, 59700}, '{32'h09, 32'h09, 65700}, '{32'h2a, 32'h2a, 71400},
        '{32'h13, 32'h13, 75400}, '{32'h34, 32'h34, 80850}, '{32'h1d, 32'h1d, 84800},
        '{32'h3e, 32'h3e, 107600}, '{32'h27, 32'h27, 132200}};
    ftps_tone_select dut (.ref_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .tx_data_i, .tone_o, .bit_tick_o, .tx_filter_sel_o,
        .rx_filter_sel_o, .filter_retune_o);
    ftps_line_peer u_peer (.clk_i(ref_clk_i), .rst_n_i(reset_n_i), .tone_i(tone_o), .start_i(start),
        .done_o(done), .cycles_o(cyc));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic near(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if ($isunknown(g) || g + 32'h2 < e || g > e + 32'h2) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : near
    task automatic end_sim;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic hang;
        err_total++;
        end_sim;
    endtask : hang
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int i;
        @(posedge ref_clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_wstrb_i   <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o === 1'b1) break;
        end
        s_axi_bready_i <= 1'b0;
        if (i == 50) hang;
        cmp(32'(s_axi_bresp_o), 32'(er));
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge ref_clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1) break;
        end
        s_axi_rready_i <= 1'b0;
        if (i == 50) hang;
        cmp(s_axi_rdata_o & m, e);
        cmp(32'(s_axi_rresp_o), 32'(er));
    endtask : rd
    task automatic tone(input int hz);
        int i;
        @(posedge ref_clk_i);
        start <= 1'b1;
        @(posedge ref_clk_i);
        start <= 1'b0;
        for (i = 0; i < 8000; i++) begin
            @(posedge ref_clk_i);
            if (done === 1'b1) break;
        end
        if (i == 8000) hang;
        near(32'(cyc), 32'(320000000 / hz));
    endtask : tone
    task automatic tick(output int c);
        for (c = 1; c < 40000; c++) begin
            @(posedge ref_clk_i);
            if (bit_tick_o === 1'b1) return;
        end
        hang;
    endtask : tick
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (filter_retune_o === 1'b1) rt_n++;
    end
    initial begin
        reset_n_i = 1'b0;
        tx_data_i = 1'b1;
        {start, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, s_axi_wdata_i} = '0;
        repeat (8) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(4'h0, 32'hffffffff, 32'h10, 2'h0);
        cmp(32'({tx_filter_sel_o, rx_filter_sel_o}), 32'h0);
        prev = 3'h0;
        foreach (rows[i]) begin
            n = rt_n;
            wr(4'h0, rows[i].ctrl, 4'hf, 2'h0);
            repeat (4) @(posedge ref_clk_i);
            cmp(32'(rt_n - n), 32'(rows[i].ctrl[2:0] != prev));
            cmp(32'({tx_filter_sel_o, rx_filter_sel_o}), 32'({2{rows[i].ctrl[2:0]}}));
            rd(4'h0, 32'hffffffff, rows[i].rb, 2'h0);
            tone(rows[i].hz);
            prev = rows[i].ctrl[2:0];
        end
        wr(4'h0, 32'h3e, 4'hf, 2'h0);
        tx_data_i <= 1'b0;
        tick(k);
        tick(k);
        cmp(32'(k), 32'h1046);
        rd(4'h4, 32'h80, 32'h0, 2'h0);
        tone(112400);
        wr(4'h8, 32'h0, 4'hf, 2'h2);
        wr(4'h4, 32'h0, 4'hf, 2'h0);
        wr(4'h0, 32'h0, 4'he, 2'h0);
        rd(4'h0, 32'hffffffff, 32'h3e, 2'h0);
        rd(4'hc, 32'hffffffff, 32'h0, 2'h2);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(4'h0, 32'hffffffff, 32'h10, 2'h0);
        tick(k);
        tick(k);
        cmp(32'(k), 32'h208d);
        end_sim;
    end
endmodule : testbench
`default_nettype wire
